// ==== inc/pifc_regs.vh ====
// Register map, field layout and reset values of the port ingress
// filter control block. Assumes a 12-bit byte address within the port.
`ifndef PIFC_REGS_VH
`define PIFC_REGS_VH

// =====================================================================
// Register offsets (byte addresses)
`define PIFC_OFS_DROP_POLICY 12'hA00
`define PIFC_OFS_FWD_MEMBER  12'hA04
`define PIFC_OFS_LK_OPTIONS  12'hB00
`define PIFC_OFS_GLOBAL_CTL  12'h000
`define PIFC_OFS_SELF_MAC_LO 12'h004
`define PIFC_OFS_SELF_MAC_HI 12'h008
`define PIFC_OFS_DROP_COUNT  12'h00C
`define PIFC_OFS_LAST_REASON 12'h010

// =====================================================================
// Field positions of the lookup options register and of the global control SAF bit
`define PIFC_BIT_NULL_VID    7
`define PIFC_BIT_ING_FILT    6
`define PIFC_BIT_NON_PORT_DEFAULT_VLAN_ID    5
`define PIFC_BIT_MAC_AUTH    4
`define PIFC_BIT_SELF_FILT   3
`define PIFC_BIT_GLOBAL_SAF  0

// =====================================================================
// Reset values and writable masks
`define PIFC_RST_DROP_POLICY 2'h0
`define PIFC_RST_FWD_MEMBER  7'h7F
`define PIFC_RST_LK_OPTIONS  8'h00
`define PIFC_WMASK_LK_OPTS   8'hFA

// =====================================================================
// Drop policy codes and bus responses
`define PIFC_POL_NO_DROP     2'h0
`define PIFC_RESP_OKAY       2'h0
`define PIFC_RESP_SLVERR     2'h2

`endif

// ==== rtl/pifc_axil_slave.v ====
// AXI4-Lite slave front end: handshakes, one write and one read at once.
// Assumes the parent decodes wr_addr/rd_addr combinationally.
`timescale 1ns/1ps
`include "pifc_regs.vh"

module pifc_axil_slave (
    aclk,
    aresetn,
    s_awaddr, s_awvalid, s_awready,
    s_wdata, s_wstrb, s_wvalid, s_wready,
    s_bresp, s_bvalid, s_bready,
    s_araddr, s_arvalid, s_arready,
    s_rdata, s_rresp, s_rvalid, s_rready,
    wr_en, wr_addr, wr_data, wr_strb, wr_err,
    rd_addr, rd_data, rd_err
);
    input  wire        aclk;
    input  wire        aresetn;
    input  wire [11:0] s_awaddr;
    input  wire        s_awvalid;
    output reg         s_awready;
    input  wire [31:0] s_wdata;
    input  wire [3:0]  s_wstrb;
    input  wire        s_wvalid;
    output reg         s_wready;
    output reg  [1:0]  s_bresp;
    output reg         s_bvalid;
    input  wire        s_bready;
    input  wire [11:0] s_araddr;
    input  wire        s_arvalid;
    output reg         s_arready;
    output reg  [31:0] s_rdata;
    output reg  [1:0]  s_rresp;
    output reg         s_rvalid;
    input  wire        s_rready;
    output wire        wr_en;
    output reg  [11:0] wr_addr;
    output reg  [31:0] wr_data;
    output reg  [3:0]  wr_strb;
    input  wire        wr_err;
    output reg  [11:0] rd_addr;
    input  wire [31:0] rd_data;
    input  wire        rd_err;

    reg rd_pend_reg;

    // Write fires once both halves are held and no response is pending
    assign wr_en = ~s_awready & ~s_wready & ~s_bvalid;

    // =====================================================================
    // Write channels
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= `PIFC_RESP_OKAY;
            wr_addr   <= 12'h000;
            wr_data   <= 32'h00000000;
            wr_strb   <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                wr_addr   <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                wr_data  <= s_wdata;
                wr_strb  <= s_wstrb;
                s_wready <= 1'b0;
            end
            if (wr_en) begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_err ? `PIFC_RESP_SLVERR : `PIFC_RESP_OKAY;
            end
            // Reopen both channels only after the response is taken
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // =====================================================================
    // Read channels; data is sampled one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_arready   <= 1'b1;
            s_rvalid    <= 1'b0;
            s_rdata     <= 32'h00000000;
            s_rresp     <= `PIFC_RESP_OKAY;
            rd_addr     <= 12'h000;
            rd_pend_reg <= 1'b0;
        end else begin
            if (s_arvalid && s_arready) begin
                rd_addr     <= s_araddr;
                s_arready   <= 1'b0;
                rd_pend_reg <= 1'b1;
            end
            if (rd_pend_reg) begin
                rd_pend_reg <= 1'b0;
                s_rvalid    <= 1'b1;
                s_rdata     <= rd_data;
                s_rresp     <= rd_err ? `PIFC_RESP_SLVERR : `PIFC_RESP_OKAY;
            end
            if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
endmodule

// ==== rtl/pifc_frame_filter.v ====
// Combinational ingress verdict for one frame descriptor.
// Assumes the parent registers every result it drives out.
`timescale 1ns/1ps
`include "pifc_regs.vh"

module pifc_frame_filter #(
    parameter NPORTS = 7
) (
    drop_policy, member_mask, lk_options, global_saf, self_mac,
    port_default_vlan_id,
    frm_tagged, frm_vid, frm_prio, frm_sa, frm_dst_mask, frm_vlan_member,
    dst_congested,
    lookup_vid, fwd_mask, flow_ctrl, drop, reason
);
    input  wire [1:0]        drop_policy;
    input  wire [NPORTS-1:0] member_mask;
    input  wire [7:0]        lk_options;
    input  wire              global_saf;
    input  wire [47:0]       self_mac;
    input  wire [11:0]       port_default_vlan_id;
    input  wire              frm_tagged;
    input  wire [11:0]       frm_vid;
    input  wire [2:0]        frm_prio;
    input  wire [47:0]       frm_sa;
    input  wire [NPORTS-1:0] frm_dst_mask;
    input  wire              frm_vlan_member;
    input  wire              dst_congested;
    output wire [11:0]       lookup_vid;
    output wire [NPORTS-1:0] fwd_mask;
    output wire              flow_ctrl;
    output wire              drop;
    output wire [3:0]        reason;

    wire null_vid  = frm_tagged & (frm_vid == 12'h000);
    wire [11:0] eff_vid = frm_tagged ? frm_vid : port_default_vlan_id;
    wire cong_drop;
    wire ing_drop;
    wire port_default_vlan_id_drop;
    wire self_drop;

    // Null VID looks up as zero only on request, else as the default VID
    assign lookup_vid = null_vid ?
        (lk_options[`PIFC_BIT_NULL_VID] ? 12'h000 : port_default_vlan_id)
        : eff_vid;
    // Membership is a plain port mask, blind to tags and VLAN table
    assign fwd_mask = frm_dst_mask & member_mask;
    // Policy n drops priorities below n; flow control only in no-drop
    assign cong_drop = dst_congested &
        ({1'b0, frm_prio} < {2'b00, drop_policy});
    assign flow_ctrl = dst_congested &
        (drop_policy == `PIFC_POL_NO_DROP);
    assign ing_drop  = lk_options[`PIFC_BIT_ING_FILT] &
        ~frm_vlan_member;
    assign port_default_vlan_id_drop = lk_options[`PIFC_BIT_NON_PORT_DEFAULT_VLAN_ID] &
        (eff_vid != port_default_vlan_id);
    // Both the port bit and the global bit must be set
    assign self_drop = lk_options[`PIFC_BIT_SELF_FILT] & global_saf &
        (frm_sa == self_mac);
    assign reason = {self_drop, port_default_vlan_id_drop, ing_drop, cong_drop};
    assign drop   = |reason;
endmodule

// ==== rtl/pifc_top.v ====
// Per-port ingress filter control: register bank over AXI4-Lite plus the
// registered verdict for each frame descriptor offered by the ingress path.
// Assumes one clock, a synchronous active-low reset and a lookup engine
// that supplies VLAN table membership with each descriptor.
`timescale 1ns/1ps
`include "pifc_regs.vh"

// Summary of operation
// - Policy 00: no drop, assert flow control
// - Policies 01-11 drop low priorities, no flow control
// - Membership mask bit per port, reset all ones
// - Membership mask ignores VLAN tags and table
// - Null VID lookup uses zero or default VID
// - Ingress filtering drops frames outside VLAN membership
// - Drop frames whose VID differs from default
// - Enable MAC authentication inside lookup engine
// - Drop frames whose source equals own MAC
// - Self filtering needs port and global enables
module pifc_top #(
    parameter NPORTS = 7
) (
    aclk,
    aresetn,
    s_awaddr,
    s_awvalid,
    s_awready,
    s_wdata,
    s_wstrb,
    s_wvalid,
    s_wready,
    s_bresp,
    s_bvalid,
    s_bready,
    s_araddr,
    s_arvalid,
    s_arready,
    s_rdata,
    s_rresp,
    s_rvalid,
    s_rready,
    port_default_vlan_id,
    frm_valid,
    frm_tagged,
    frm_vid,
    frm_prio,
    frm_sa,
    frm_dst_mask,
    frm_vlan_member,
    dst_congested,
    dec_valid,
    dec_drop,
    dec_reason,
    dec_fwd_mask,
    dec_lookup_vid,
    flow_ctrl_req,
    mac_auth_en
);
    input  wire              aclk;
    input  wire              aresetn;
    input  wire [11:0]       s_awaddr;
    input  wire              s_awvalid;
    output wire              s_awready;
    input  wire [31:0]       s_wdata;
    input  wire [3:0]        s_wstrb;
    input  wire              s_wvalid;
    output wire              s_wready;
    output wire [1:0]        s_bresp;
    output wire              s_bvalid;
    input  wire              s_bready;
    input  wire [11:0]       s_araddr;
    input  wire              s_arvalid;
    output wire              s_arready;
    output wire [31:0]       s_rdata;
    output wire [1:0]        s_rresp;
    output wire              s_rvalid;
    input  wire              s_rready;
    input  wire [11:0]       port_default_vlan_id;
    input  wire              frm_valid;
    input  wire              frm_tagged;
    input  wire [11:0]       frm_vid;
    input  wire [2:0]        frm_prio;
    input  wire [47:0]       frm_sa;
    input  wire [NPORTS-1:0] frm_dst_mask;
    input  wire              frm_vlan_member;
    input  wire              dst_congested;
    output reg               dec_valid;
    output reg               dec_drop;
    output reg  [3:0]        dec_reason;
    output reg  [NPORTS-1:0] dec_fwd_mask;
    output reg  [11:0]       dec_lookup_vid;
    output reg               flow_ctrl_req;
    output reg               mac_auth_en;

    // =====================================================================
    // Byte-lane merge used by every writable register
    function [31:0] pifc_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        integer i;
        begin
            pifc_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    pifc_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Address decode, shared by the write and read paths
    function pifc_mapped;
        input [11:0] addr;
        begin
            case (addr)
                `PIFC_OFS_DROP_POLICY,
                `PIFC_OFS_FWD_MEMBER,
                `PIFC_OFS_LK_OPTIONS,
                `PIFC_OFS_GLOBAL_CTL,
                `PIFC_OFS_SELF_MAC_LO,
                `PIFC_OFS_SELF_MAC_HI,
                `PIFC_OFS_DROP_COUNT,
                `PIFC_OFS_LAST_REASON: pifc_mapped = 1'b1;
                default:               pifc_mapped = 1'b0;
            endcase
        end
    endfunction

    // =====================================================================
    // Register state
    reg  [1:0]        drop_policy_reg;
    reg  [NPORTS-1:0] member_reg;
    reg  [7:0]        lk_options_reg;
    reg               global_saf_reg;
    reg  [47:0]       self_mac_reg;
    reg  [31:0]       drop_count_reg;
    reg  [3:0]        last_reason_reg;
    reg  [31:0]       rd_mux;

    wire              wr_en;
    wire [11:0]       wr_addr;
    wire [31:0]       wr_data;
    wire [3:0]        wr_strb;
    wire [11:0]       rd_addr;
    wire [31:0]       wr_word;
    wire [11:0]       f_lookup_vid;
    wire [NPORTS-1:0] f_fwd_mask;
    wire              f_flow_ctrl;
    wire              f_drop;
    wire [3:0]        f_reason;

    // Old value read back so partial strobes keep untouched lanes
    assign wr_word = pifc_merge(rd_mux_w(wr_addr), wr_data, wr_strb);

    // =====================================================================
    // Bus front end
    pifc_axil_slave u_bus (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_err    (~pifc_mapped(wr_addr)),
        .rd_addr   (rd_addr),
        .rd_data   (rd_mux),
        .rd_err    (~pifc_mapped(rd_addr))
    );

    // =====================================================================
    // Read view; unused bits above each field are forced to zero here
    function [31:0] rd_mux_w;
        input [11:0] addr;
        begin
            case (addr)
                `PIFC_OFS_DROP_POLICY:
                    rd_mux_w = {30'h00000000, drop_policy_reg};
                `PIFC_OFS_FWD_MEMBER:
                    rd_mux_w = {{(32-NPORTS){1'b0}}, member_reg};
                `PIFC_OFS_LK_OPTIONS:
                    rd_mux_w = {24'h000000, lk_options_reg};
                `PIFC_OFS_GLOBAL_CTL:
                    rd_mux_w = {31'h00000000, global_saf_reg};
                `PIFC_OFS_SELF_MAC_LO:
                    rd_mux_w = self_mac_reg[31:0];
                `PIFC_OFS_SELF_MAC_HI:
                    rd_mux_w = {16'h0000, self_mac_reg[47:32]};
                `PIFC_OFS_DROP_COUNT:
                    rd_mux_w = drop_count_reg;
                `PIFC_OFS_LAST_REASON:
                    rd_mux_w = {28'h0000000, last_reason_reg};
                default:
                    rd_mux_w = 32'h00000000;
            endcase
        end
    endfunction

    always @* begin
        rd_mux = rd_mux_w(rd_addr);
    end

    // =====================================================================
    // Software writes; only documented fields and lk_options bit 1 take the written value
    always @(posedge aclk) begin
        if (!aresetn) begin
            drop_policy_reg <= `PIFC_RST_DROP_POLICY;
            member_reg      <= {NPORTS{1'b1}};
            lk_options_reg  <= `PIFC_RST_LK_OPTIONS;
            global_saf_reg  <= 1'b0;
            self_mac_reg    <= 48'h000000000000;
        end else if (wr_en) begin
            case (wr_addr)
                `PIFC_OFS_DROP_POLICY:
                    drop_policy_reg <= wr_word[1:0];
                `PIFC_OFS_FWD_MEMBER:
                    member_reg <= wr_word[NPORTS-1:0];
                `PIFC_OFS_LK_OPTIONS:
                    lk_options_reg <= wr_word[7:0] &
                        `PIFC_WMASK_LK_OPTS;
                `PIFC_OFS_GLOBAL_CTL:
                    global_saf_reg <= wr_word[`PIFC_BIT_GLOBAL_SAF];
                `PIFC_OFS_SELF_MAC_LO:
                    self_mac_reg[31:0] <= wr_word;
                `PIFC_OFS_SELF_MAC_HI:
                    self_mac_reg[47:32] <= wr_word[15:0];
                default: begin
                end
            endcase
        end
    end

    // =====================================================================
    // Frame verdict
    pifc_frame_filter #(
        .NPORTS (NPORTS)
    ) u_filter (
        .drop_policy          (drop_policy_reg),
        .member_mask          (member_reg),
        .lk_options           (lk_options_reg),
        .global_saf           (global_saf_reg),
        .self_mac             (self_mac_reg),
        .port_default_vlan_id (port_default_vlan_id),
        .frm_tagged           (frm_tagged),
        .frm_vid              (frm_vid),
        .frm_prio             (frm_prio),
        .frm_sa               (frm_sa),
        .frm_dst_mask         (frm_dst_mask),
        .frm_vlan_member      (frm_vlan_member),
        .dst_congested        (dst_congested),
        .lookup_vid           (f_lookup_vid),
        .fwd_mask             (f_fwd_mask),
        .flow_ctrl            (f_flow_ctrl),
        .drop                 (f_drop),
        .reason               (f_reason)
    );

    // Verdicts leave one cycle after the descriptor; a dropped frame
    // still reports its mask, the consumer must honour dec_drop first
    always @(posedge aclk) begin
        if (!aresetn) begin
            dec_valid      <= 1'b0;
            dec_drop       <= 1'b0;
            dec_reason     <= 4'h0;
            dec_fwd_mask   <= {NPORTS{1'b0}};
            dec_lookup_vid <= 12'h000;
            flow_ctrl_req  <= 1'b0;
            mac_auth_en    <= 1'b0;
            drop_count_reg <= 32'h00000000;
            last_reason_reg <= 4'h0;
        end else begin
            dec_valid      <= frm_valid;
            dec_drop       <= frm_valid & f_drop;
            dec_reason     <= frm_valid ? f_reason : 4'h0;
            dec_fwd_mask   <= frm_valid ? f_fwd_mask
                                        : {NPORTS{1'b0}};
            dec_lookup_vid <= frm_valid ? f_lookup_vid
                                        : 12'h000;
            // Backpressure tracks congestion, not descriptor timing
            flow_ctrl_req  <= f_flow_ctrl;
            mac_auth_en    <= lk_options_reg[`PIFC_BIT_MAC_AUTH];
            if (frm_valid && f_drop) begin
                drop_count_reg  <= drop_count_reg + 32'h00000001;
                last_reason_reg <= f_reason;
            end
        end
    end
endmodule

// ==== tb/pifc_monitor.sv ====
// Checker for the ingress filter control block, watching top-level ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
// =====================================================================
// Port checker
module pifc_monitor #(
    parameter NPORTS = 7
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_rvalid,
    input wire logic [1:0]        s_rresp,
    input wire logic [31:0]       s_rdata,
    input wire logic [11:0]       port_default_vlan_id,
    input wire logic              frm_valid,
    input wire logic              frm_tagged,
    input wire logic [11:0]       frm_vid,
    input wire logic [2:0]        frm_prio,
    input wire logic [NPORTS-1:0] frm_dst_mask,
    input wire logic              frm_vlan_member,
    input wire logic              dst_congested,
    input wire logic              dec_valid,
    input wire logic              dec_drop,
    input wire logic [3:0]        dec_reason,
    input wire logic [NPORTS-1:0] dec_fwd_mask,
    input wire logic [11:0]       dec_lookup_vid,
    input wire logic              flow_ctrl_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Verdicts track descriptors with a one-cycle lag
    property p_cong;
        dec_reason[0] |-> $past(dst_congested) && $past(frm_prio) < 3'h3;
    endproperty
    a_cong: assert property (p_cong) else $error("bad congestion drop");
    property p_fc;
        flow_ctrl_req && dec_valid |-> !dec_reason[0];
    endproperty
    a_fc: assert property (p_fc) else $error("drop under flow ctl");
    property p_fcc;
        flow_ctrl_req |-> $past(dst_congested);
    endproperty
    a_fcc: assert property (p_fcc) else $error("flow ctl w/o cong");
    property p_mask;
        dec_valid |-> (dec_fwd_mask & ~$past(frm_dst_mask)) == '0;
    endproperty
    a_mask: assert property (p_mask) else $error("mask widened");
    property p_untag;
        frm_valid && !frm_tagged
            |=> dec_lookup_vid == $past(port_default_vlan_id);
    endproperty
    a_untag: assert property (p_untag) else $error("untag lookup vid");
    property p_tagv;
        frm_valid && frm_tagged && frm_vid != 12'h000
            |=> dec_lookup_vid == $past(frm_vid);
    endproperty
    a_tagv: assert property (p_tagv) else $error("tagged lookup vid");
    property p_ingr;
        dec_reason[1] |-> !$past(frm_vlan_member);
    endproperty
    a_ingr: assert property (p_ingr) else $error("ingress drop");
    property p_npv;
        dec_reason[2] |-> $past(frm_tagged)
            && $past(frm_vid) != $past(port_default_vlan_id);
    endproperty
    a_npv: assert property (p_npv) else $error("non-default drop");
    property p_drop;
        dec_drop == (dec_reason != 4'h0);
    endproperty
    a_drop: assert property (p_drop) else $error("drop vs reason");
    property p_err;
        s_rvalid && s_rresp == 2'h2 |-> s_rdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error read data");
    c_cong: cover property (dec_reason[0]);
    c_fc: cover property (flow_ctrl_req);
    c_self: cover property (dec_reason[3]);
endmodule

bind pifc_top pifc_monitor #(.NPORTS(NPORTS)) u_mon (.*);

// ==== tb/tb_port_ingress_filter_control.sv ====
// Self-checking bench for the ingress filter control block.
// Assumes the register map header and an AXI4-Lite register path.
`timescale 1ns/1ps
`include "pifc_regs.vh"
// =====================================================================
// Bench top
module tb_port_ingress_filter_control;
    localparam [11:0] DVID = 12'h123;
    localparam [47:0] MAC  = 48'hA1B2C3D4E5F6;
    logic aclk = 0, aresetn = 0;
    logic [11:0] s_awaddr = 0, s_araddr = 0, frm_vid = 0;
    logic [31:0] s_wdata = 0;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rready = 0, frm_valid = 0, frm_tagged = 0;
    logic frm_vlan_member = 1, dst_congested = 0;
    logic [2:0] frm_prio = 0;
    logic [47:0] frm_sa = 0;
    logic [6:0] frm_dst_mask = 7'h7F;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire [1:0] s_bresp, s_rresp;
    wire [31:0] s_rdata;
    wire dec_valid, dec_drop, flow_ctrl_req, mac_auth_en;
    wire [3:0] dec_reason;
    wire [6:0] dec_fwd_mask;
    wire [11:0] dec_lookup_vid;
    integer error_cnt = 0, checks_done = 0;
    logic [1:0] rsp;
    logic [31:0] rd;

    pifc_top #(.NPORTS(7)) dut (.*,
        .port_default_vlan_id (DVID));

    // Clock at 200 MHz
    always #2.5 aclk = ~aclk;

    task chk(input string nm, input logic [47:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // AXI write: each channel released at its own handshake
    task axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_awaddr <= a; s_wdata <= d;
        s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
        fork
            begin do @(posedge aclk); while (!s_awready); s_awvalid <= 0; end
            begin do @(posedge aclk); while (!s_wready); s_wvalid <= 0; end
        join
        while (!s_bvalid) @(posedge aclk);
        rsp = s_bresp;
        s_bready <= 0;
        @(posedge aclk);
    endtask

    task axr(input logic [11:0] a);
        @(posedge aclk);
        s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 0;
        while (!s_rvalid) @(posedge aclk);
        rd = s_rdata; rsp = s_rresp;
        s_rready <= 0;
        @(posedge aclk);
    endtask

    // One descriptor; verdict stands only until the next edge
    task frm(input logic tg, input logic [11:0] v, input logic [2:0] p,
             input logic cg, mem, input logic [47:0] sa);
        @(posedge aclk);
        frm_valid <= 1; frm_tagged <= tg; frm_vid <= v; frm_prio <= p;
        dst_congested <= cg; frm_vlan_member <= mem; frm_sa <= sa;
        @(posedge aclk);
        frm_valid <= 0;
        #1;
        chk("dec_valid", dec_valid, 1);
    endtask

    // Reset values, unmapped and reserved bits
    task t_reset;
        axr(`PIFC_OFS_DROP_POLICY); chk("policy", rd, 0);
        axr(`PIFC_OFS_FWD_MEMBER); chk("member", rd, 32'h7F);
        axr(`PIFC_OFS_LK_OPTIONS); chk("opts", rd, 0);
        axr(12'h800); chk("unmapped", {rsp, rd}, 34'h200000000);
        axw(12'h800, 32'hFFFFFFFF); chk("wr_unmapped", rsp, 2'h2);
        axw(`PIFC_OFS_LK_OPTIONS, 32'hFFFFFFFF); chk("wr_ok", rsp, 0);
        axr(`PIFC_OFS_LK_OPTIONS); chk("opts_rsvd", rd, 32'hFA);
        axw(`PIFC_OFS_LK_OPTIONS, 32'h0);
    endtask

    // Every drop policy against every low priority while congested
    task t_policy;
        for (int pol = 0; pol < 4; pol++) begin
            axw(`PIFC_OFS_DROP_POLICY, pol);
            for (int p = 0; p < 4; p++) begin
                frm(0, 0, p, 1, 1, 0);
                chk("cong_drop", dec_drop, p < pol);
                chk("flow_ctrl", flow_ctrl_req, pol == 0);
            end
        end
        @(posedge aclk);
        dst_congested <= 0;
        axw(`PIFC_OFS_DROP_POLICY, 0);
    endtask

    // Membership mask ignores tag and table membership
    task t_member;
        axw(`PIFC_OFS_FWD_MEMBER, 32'hFFFFFF55);
        axr(`PIFC_OFS_FWD_MEMBER); chk("member_rd", rd, 32'h55);
        // Strobe on a lane above the field must leave the mask alone
        s_wstrb <= 4'h2;
        axw(`PIFC_OFS_FWD_MEMBER, 32'h0);
        s_wstrb <= 4'hF;
        axr(`PIFC_OFS_FWD_MEMBER); chk("member_strb", rd, 32'h55);
        frm(1, 12'h005, 0, 0, 0, 0);
        chk("fwd", {dec_drop, dec_fwd_mask}, 8'h55);
        @(posedge aclk);
        frm_dst_mask <= 7'h0F;
        frm(0, 0, 0, 0, 1, 0);
        chk("fwd2", dec_fwd_mask, 7'h05);
        @(posedge aclk);
        frm_dst_mask <= 7'h7F;
        axw(`PIFC_OFS_FWD_MEMBER, 32'h7F);
    endtask

    // Lookup options one bit at a time
    task t_opts;
        axw(`PIFC_OFS_LK_OPTIONS, 32'h80);
        frm(1, 0, 0, 0, 1, 0); chk("nullvid1", dec_lookup_vid, 0);
        axw(`PIFC_OFS_LK_OPTIONS, 32'h00);
        frm(1, 0, 0, 0, 1, 0); chk("nullvid0", dec_lookup_vid, DVID);
        frm(1, 12'h077, 0, 0, 0, 0); chk("nofilt", dec_drop, 0);
        axw(`PIFC_OFS_LK_OPTIONS, 32'h40);
        frm(1, 12'h077, 0, 0, 0, 0); chk("ingr", dec_reason, 4'h2);
        axw(`PIFC_OFS_LK_OPTIONS, 32'h20);
        frm(1, 12'h077, 0, 0, 1, 0); chk("npvid", dec_reason, 4'h4);
        frm(1, DVID, 0, 0, 1, 0); chk("port_default_vlan_id", dec_drop, 0);
        axw(`PIFC_OFS_LK_OPTIONS, 32'h10);
        @(posedge aclk); #1;
        chk("auth", mac_auth_en, 1);
        axw(`PIFC_OFS_SELF_MAC_LO, MAC[31:0]);
        axw(`PIFC_OFS_SELF_MAC_HI, {16'h0, MAC[47:32]});
        axw(`PIFC_OFS_LK_OPTIONS, 32'h08);
        frm(0, 0, 0, 0, 1, MAC); chk("self_nog", dec_drop, 0);
        axw(`PIFC_OFS_GLOBAL_CTL, 32'h1);
        frm(0, 0, 0, 0, 1, MAC); chk("self", dec_reason, 4'h8);
        frm(0, 0, 0, 0, 1, MAC ^ 48'h1); chk("self_mis", dec_drop, 0);
        axw(`PIFC_OFS_LK_OPTIONS, 32'h00);
        frm(0, 0, 0, 0, 1, MAC); chk("self_nop", dec_drop, 0);
        // Six congestion drops plus ingress, non-default and self drops
        axr(`PIFC_OFS_DROP_COUNT); chk("drops", rd, 9);
        axr(`PIFC_OFS_LAST_REASON); chk("last_rsn", rd, 4'h8);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset;
        t_policy;
        t_member;
        t_opts;
        summarize;
    end

    // Watchdog, well beyond the expected run
    initial begin
        #50000;
        error_cnt++;
        summarize;
    end
endmodule
